// ===== bench/gpc_pad_model.sv
// Pad model: each pad carries the controller drive, else the bench level.
// Assumes the bench drives every pad that the controller leaves open.
`timescale 1ns/10ps
module gpc_pad_model (
    input  wire logic [31:0] out_i,
    input  wire logic [31:0] oe_n_i,
    input  wire logic [31:0] ext_i,
    output logic      [31:0] pad_o
);
    // The low enable means driven; the controller then wins over the bench.
    assign pad_o = (~oe_n_i & out_i) | (oe_n_i & ext_i);
endmodule : gpc_pad_model

// ===== bench/tb_gpc_pin_ctrl.sv
// Bench of the pin controller: bus traffic, pad drive and interrupts,
// checked against the register model rm. Assumes gpc_pad_model on the pads.
`timescale 1ns/10ps
module tb_gpc_pin_ctrl import gpc_pkg::*;;
    logic        mclk_i = 1'b0, resetn_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
    logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
    logic [7:0]  awaddr_i, araddr_i;
    logic [1:0]  bresp_o, rresp_o, r;
    logic [3:0]  wstrb_i = 4'hf;
    logic [31:0] wdata_i, rdata_o, pad_in_i, pad_out_o, pad_oe_n_o, pad_sense_en_o, pad_pullup_o;
    logic [31:0] pad_strength_o, fn0_out_i, fn0_drive_i, fn1_out_i, fn1_drive_i, fn_level_o;
    logic [31:0] irq_pin_o, ext, d, e, m, en, rm [0:20];
    int          n_mismatch = 0, n_tests = 0, k;
    int          outs [7] = '{2, 3, 4, 5, 14, 15, 16};
    // Device under test; the pad model closes the loop onto pad_in_i.
    gpc_pin_ctrl i_dut (.mclk_i, .resetn_i, .awvalid_i, .awready_o, .awaddr_i, .wvalid_i,
        .wready_o, .wdata_i, .wstrb_i, .bvalid_o, .bready_i, .bresp_o, .arvalid_i, .arready_o,
        .araddr_i, .rvalid_o, .rready_i, .rdata_o, .rresp_o, .pad_in_i, .pad_out_o, .pad_oe_n_o,
        .pad_sense_en_o, .pad_pullup_o, .pad_strength_o, .fn0_out_i, .fn0_drive_i, .fn1_out_i,
        .fn1_drive_i, .fn_level_o, .irq_pin_o, .irq_o);
    gpc_pad_model i_pad (.out_i(pad_out_o), .oe_n_i(pad_oe_n_o), .ext_i(ext), .pad_o(pad_in_i));
    // The 200 MHz bus clock.
    always #2.5 mclk_i = ~mclk_i;
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, x);
        end
    endtask : chk
    task automatic close_out();
        $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    // One bus transfer; every channel is held until its ready, and no wait is open-ended.
    task automatic bus(input bit we, input logic [7:0] ad, input logic [31:0] v);
        int n;
        @(posedge mclk_i);
        {awaddr_i, araddr_i, wdata_i} <= {ad, ad, v};
        {awvalid_i, wvalid_i, bready_i} <= {3{we}};
        {arvalid_i, rready_i} <= {2{!we}};
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
            if (awready_o) awvalid_i <= 1'b0;
            if (wready_o) wvalid_i <= 1'b0;
            if (arready_o) arvalid_i <= 1'b0;
        end while (bvalid_o !== 1'b1 && rvalid_o !== 1'b1 && n < 100);
        {bready_i, rready_i} <= 2'b00;
        d = rdata_o;
        r = we ? bresp_o : rresp_o;
        if (n == 100) begin
            n_mismatch++;
            close_out();
        end
    endtask : bus
    task automatic rc(input logic [7:0] ad, input logic [31:0] x);
        bus(0, ad, 32'h0);
        chk(d, x);
    endtask : rc
    // Pending bits first, so the sticky status cannot be set again behind us.
    task automatic clr();
        for (int i = 7; i <= 19; i += 2) if (i < 14 || i == 19) bus(1, 8'(4 * i), 32'hffff_ffff);
    endtask : clr
    // Main sequence: reset, registers, pad drive, sensing, interrupts.
    initial begin
        {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, resetn_i} = 6'h00;
        {awaddr_i, araddr_i, wdata_i, ext} = 80'h0;
        {fn0_out_i, fn0_drive_i, fn1_out_i, fn1_drive_i} = 128'h0;
        k = $urandom(32'hb55e1e90);
        repeat (5) @(posedge mclk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        chk(pad_oe_n_o, RST_OE_N);
        chk(pad_pullup_o, 32'h0);
        for (k = 0; k <= 20; k++) rc(8'(4 * k), 32'h0);
        for (int p = 0; p < 2; p++) begin
            for (k = 1; k <= 20; k++) begin
                if (k == 19 || (k >= 7 && k <= 13 && k % 2 == 1)) continue;
                rm[k] = p ? 32'h0 : $urandom;
                bus(1, 8'(4 * k), rm[k]);
                chk(32'(r), 32'(RESP_OKAY));
                rc(8'(4 * k), rm[k]);
                chk(32'(r), 32'(RESP_OKAY));
            end
        end
        bus(1, 8'h54, 32'hffff_ffff);
        chk(32'(r), 32'(RESP_SLVERR));
        bus(1, OFF_LEVEL, 32'hffff_ffff);
        chk(32'(r), 32'(RESP_SLVERR));
        rc(8'h54, 32'h0);
        chk(32'(r), 32'(RESP_SLVERR));
        repeat (4) begin
            foreach (outs[i]) begin
                rm[outs[i]] = $urandom;
                bus(1, 8'(4 * outs[i]), rm[outs[i]]);
            end
            {fn0_out_i, fn0_drive_i, fn1_out_i, fn1_drive_i} <= {$urandom, $urandom, $urandom, $urandom};
            repeat (2) @(posedge mclk_i);
            en = rm[14] & ((~rm[15] & FN0_EXISTS) | (rm[15] & FN1_EXISTS));
            e = en & rm[15];
            m = en & ~rm[15];
            chk(pad_out_o, (m & fn0_out_i | e & fn1_out_i | ~en & rm[3]) ^ rm[16]);
            chk(pad_oe_n_o, ~(m & fn0_drive_i | e & fn1_drive_i | ~en & rm[2]));
            chk(pad_strength_o, rm[5]);
            chk(pad_pullup_o, rm[4]);
        end
        // Byte lanes 0 and 2 only; the other lanes must keep their old value.
        wstrb_i <= 4'h5;
        bus(1, OFF_STRENGTH, 32'hffff_ffff);
        wstrb_i <= 4'hf;
        rc(OFF_STRENGTH, rm[5] & 32'hff00_ff00 | 32'h00ff_00ff);
        bus(1, OFF_DRIVE, 32'h0);
        bus(1, OFF_FN_EN, 32'h0);
        m = $urandom;
        bus(1, OFF_SENSE, m);
        ext <= $urandom;
        repeat (6) @(posedge mclk_i);
        rc(OFF_LEVEL, ext & m);
        chk(fn_level_o, ext & m);
        chk(pad_sense_en_o, m);
        bus(1, OFF_SENSE, 32'hffff_ffff);
        bus(1, OFF_IRQ_MASK, 32'hffff_ffff);
        for (k = 0; k < 4; k++) begin
            ext <= $urandom;
            repeat (6) @(posedge mclk_i);
            clr();
            bus(1, 8'(24 + 8 * k), 32'hffff_ffff);
            m = ext;
            ext <= $urandom;
            repeat (6) @(posedge mclk_i);
            e = k == 0 ? ~m & ext : k == 1 ? m & ~ext : k == 2 ? m | ext : ~m | ~ext;
            rc(8'(28 + 8 * k), e);
            chk(irq_pin_o, e);
            chk(32'(irq_o), 32'(|e));
            bus(1, 8'(24 + 8 * k), 32'h0);
            bus(1, 8'(28 + 8 * k), 32'h0);
            rc(8'(28 + 8 * k), e);
        end
        clr();
        m = $urandom;
        bus(1, OFF_IRQ_MASK, 32'h0);
        bus(1, OFF_DIRECT_HI, m);
        bus(1, OFF_DIRECT_LO, ~m);
        repeat (6) @(posedge mclk_i);
        e = ext & m | ~ext & ~m;
        chk(irq_pin_o, e);
        chk(32'(irq_o), 32'h0);
        rc(OFF_IRQ_STATUS, e);
        close_out();
    end
endmodule : tb_gpc_pin_ctrl

// ===== rtl/gpc_pin_ctrl.sv
// 32-pin general purpose pin controller with AXI4-Lite register access.
// Assumes pads are asynchronous and function inputs run on mclk_i.
//
// How it works
// (RULE1) Sense and drive enables are one bit per pin, set independently.
// (RULE2) Drive-level writes always store; reads return the stored value.
// (RULE3) Pin-level read is synchronised level ANDed with sense enable.
// (RULE4) Each pin has its own interrupt line, four conditions enabled separately.
// (RULE5) Pad levels pass two flip-flops before interrupt logic sees them.
// (RULE6) Edge enables arm conditions; a set pending bit raises the pin line.
// (RULE7) Pending bits stay set until software writes one to them.
// (RULE8) Pin interrupt lines leave as ports for any interrupt consumer.
// (RULE9) Each pin has a pull-up enable; reset leaves inputs, pull-ups off.
// (RULE10) Drive strength output follows the drive-strength register.
// (RULE11) The pad output value is XORed with the invert register.
// (RULE12) Per pin, a function enable and select choose one of two functions.
// (RULE13) Each function takes a fixed subset of controls; software keeps the rest.
// (RULE14) Enabling a missing function leaves the pin under software control.
// (RULE15) Sense, drive and pull-up enables reset asynchronously; others synchronously.
// (RULE16) All registers are 32 bits wide with aligned word access.
// (RULE17) Level pending bits set on any cycle at the enabled level.
// (RULE18) Direct enables pass the level or its inverse onto pin lines.
`timescale 1ns/10ps
module gpc_pin_ctrl
    import gpc_pkg::*;
(
    input  wire logic            mclk_i,
    input  wire logic            resetn_i,
    input  wire logic            awvalid_i,
    output logic                 awready_o,
    input  wire logic [AW-1:0]   awaddr_i,
    input  wire logic            wvalid_i,
    output logic                 wready_o,
    input  wire logic [31:0]     wdata_i,
    input  wire logic [3:0]      wstrb_i,
    output logic                 bvalid_o,
    input  wire logic            bready_i,
    output logic      [1:0]      bresp_o,
    input  wire logic            arvalid_i,
    output logic                 arready_o,
    input  wire logic [AW-1:0]   araddr_i,
    output logic                 rvalid_o,
    input  wire logic            rready_i,
    output logic      [31:0]     rdata_o,
    output logic      [1:0]      rresp_o,
    input  wire logic [NPIN-1:0] pad_in_i,
    output logic      [NPIN-1:0] pad_out_o,
    output logic      [NPIN-1:0] pad_oe_n_o,
    output logic      [NPIN-1:0] pad_sense_en_o,
    output logic      [NPIN-1:0] pad_pullup_o,
    output logic      [NPIN-1:0] pad_strength_o,
    input  wire logic [NPIN-1:0] fn0_out_i,
    input  wire logic [NPIN-1:0] fn0_drive_i,
    input  wire logic [NPIN-1:0] fn1_out_i,
    input  wire logic [NPIN-1:0] fn1_drive_i,
    output logic      [NPIN-1:0] fn_level_o,
    output logic      [NPIN-1:0] irq_pin_o,
    output logic                 irq_o
);

    ////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Expands byte strobes into a bit mask.
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_mask

    // Merges written bytes into an old register value.
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
        wmerge = (old & ~strb_mask(s)) | (d & strb_mask(s));
    endfunction : wmerge

    // Sticky update; the set wins over a clear in the same cycle.
    function automatic logic [31:0] pend_next(input logic [31:0] p, input logic [31:0] clr,
                                              input logic [31:0] set);
        pend_next = (p & ~clr) | set;
    endfunction : pend_next

    // Pins where an existing selected function takes over one control.
    function automatic logic [31:0] taken(input logic [31:0] on, input logic [31:0] sel,
                                          input int k);
        taken = on & ((sel & {32{FN1_TAKES[k]}}) | (~sel & {32{FN0_TAKES[k]}}));
    endfunction : taken

    ////////////////////////////////////////////////////////////////////
    // Registers.

    logic [31:0] sense_en, drive_en, pullup_en;
    logic [31:0] drive_level, strength, rise_en, rise_pend, fall_en, fall_pend;
    logic [31:0] high_en, high_pend, low_en, low_pend, fn_en, fn_sel, invert;
    logic [31:0] direct_hi, direct_lo, irq_status, irq_mask;
    logic [31:0] pin_sync, lvl_prev;
    logic        aw_full, w_full;
    logic [AW-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel: address and data are held until both arrive.

    wire         aw_take  = awvalid_i & awready_o;
    wire         w_take   = wvalid_i & wready_o;
    wire         do_wr    = aw_full & w_full & ~bvalid_o;
    wire         next_aw  = (aw_full | aw_take) & ~do_wr;
    wire         next_w   = (w_full | w_take) & ~do_wr;
    wire [7:0]   wa       = aw_addr;
    wire         wr_ok    = (wa[1:0] == 2'h0) && (wa <= OFF_IRQ_MASK) && (wa != OFF_LEVEL);
    wire [31:0]  wm       = strb_mask(w_strb);

    // Ready is registered, so a held channel refuses the next item.
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            aw_full   <= 1'b0;
            w_full    <= 1'b0;
            awready_o <= 1'b0;
            wready_o  <= 1'b0;
            bvalid_o  <= 1'b0;
            bresp_o   <= RESP_OKAY;
            aw_addr   <= '0;
            w_data    <= RST_ZERO;
            w_strb    <= 4'h0;
        end else begin
            aw_full   <= next_aw;
            w_full    <= next_w;
            awready_o <= ~next_aw;
            wready_o  <= ~next_w;
            if (aw_take) aw_addr <= awaddr_i;
            if (w_take) begin
                w_data <= wdata_i;
                w_strb <= wstrb_i;
            end
            if (do_wr) begin
                bvalid_o <= 1'b1;
                bresp_o  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bready_i) begin
                bvalid_o <= 1'b0;
            end
        end
    end

    // Per-register write strobes.
    wire we_sense  = do_wr && wa == OFF_SENSE;
    wire we_drive  = do_wr && wa == OFF_DRIVE;
    wire we_value  = do_wr && wa == OFF_VALUE;
    wire we_pullup = do_wr && wa == OFF_PULLUP;
    wire [31:0] clr_rise = (do_wr && wa == OFF_RISE_PEND)  ? (w_data & wm) : RST_ZERO;
    wire [31:0] clr_fall = (do_wr && wa == OFF_FALL_PEND)  ? (w_data & wm) : RST_ZERO;
    wire [31:0] clr_high = (do_wr && wa == OFF_HIGH_PEND)  ? (w_data & wm) : RST_ZERO;
    wire [31:0] clr_low  = (do_wr && wa == OFF_LOW_PEND)   ? (w_data & wm) : RST_ZERO;
    wire [31:0] clr_stat = (do_wr && wa == OFF_IRQ_STATUS) ? (w_data & wm) : RST_ZERO;

    ////////////////////////////////////////////////////////////////////
    // Pad-facing enables reset at once; the pads themselves float only at the next clock edge under reset.

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sense_en  <= RST_ZERO; // RULE15 RULE9
            drive_en  <= RST_ZERO;
            pullup_en <= RST_ZERO;
        end else begin
            if (we_sense) sense_en <= wmerge(sense_en, w_data, w_strb); // RULE1
            if (we_drive) drive_en <= wmerge(drive_en, w_data, w_strb); // RULE1
            if (we_pullup) pullup_en <= wmerge(pullup_en, w_data, w_strb); // RULE9
        end
    end

    // Plain software registers, stored whatever the drive state.
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            drive_level <= RST_ZERO; // RULE15
            strength    <= RST_ZERO;
            rise_en     <= RST_ZERO;
            fall_en     <= RST_ZERO;
            high_en     <= RST_ZERO;
            low_en      <= RST_ZERO;
            fn_en       <= RST_ZERO;
            fn_sel      <= RST_ZERO;
            invert      <= RST_ZERO;
            direct_hi   <= RST_ZERO;
            direct_lo   <= RST_ZERO;
            irq_mask    <= RST_ZERO;
        end else if (do_wr) begin
            case (wa)
                OFF_VALUE:     drive_level <= wmerge(drive_level, w_data, w_strb); // RULE2
                OFF_STRENGTH:  strength    <= wmerge(strength, w_data, w_strb);
                OFF_RISE_EN:   rise_en     <= wmerge(rise_en, w_data, w_strb);
                OFF_FALL_EN:   fall_en     <= wmerge(fall_en, w_data, w_strb);
                OFF_HIGH_EN:   high_en     <= wmerge(high_en, w_data, w_strb);
                OFF_LOW_EN:    low_en      <= wmerge(low_en, w_data, w_strb);
                OFF_FN_EN:     fn_en       <= wmerge(fn_en, w_data, w_strb); // RULE12
                OFF_FN_SEL:    fn_sel      <= wmerge(fn_sel, w_data, w_strb); // RULE12
                OFF_INVERT:    invert      <= wmerge(invert, w_data, w_strb);
                OFF_DIRECT_HI: direct_hi   <= wmerge(direct_hi, w_data, w_strb);
                OFF_DIRECT_LO: direct_lo   <= wmerge(direct_lo, w_data, w_strb);
                OFF_IRQ_MASK:  irq_mask    <= wmerge(irq_mask, w_data, w_strb);
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Input sampling and condition detection.

    gpc_pin_sync u_sync (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .async_i  (pad_in_i),
        .sync_o   (pin_sync)
    ); // RULE5

    // Only sensed pins are seen; a short pulse may be missed by design.
    wire [31:0] lvl      = pin_sync & sense_en; // RULE3
    wire [31:0] rise     = lvl & ~lvl_prev & rise_en; // RULE6
    wire [31:0] fall     = ~lvl & lvl_prev & fall_en; // RULE6
    wire [31:0] high_set = lvl & high_en; // RULE17
    wire [31:0] low_set  = ~lvl & low_en; // RULE17
    wire [31:0] next_rise_pend = pend_next(rise_pend, clr_rise, rise); // RULE7
    wire [31:0] next_fall_pend = pend_next(fall_pend, clr_fall, fall); // RULE7
    wire [31:0] next_high_pend = pend_next(high_pend, clr_high, high_set); // RULE7
    wire [31:0] next_low_pend  = pend_next(low_pend, clr_low, low_set); // RULE7

    // Pin line: any pending bit, plus the direct level paths.
    wire [31:0] next_irq_pin = rise_pend | fall_pend | high_pend | low_pend // RULE4 RULE6
                             | (direct_hi & lvl) | (direct_lo & ~lvl); // RULE18
    wire [31:0] next_status  = pend_next(irq_status, clr_stat, next_irq_pin);

    // Pending state and the interrupt outputs.
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            lvl_prev   <= RST_ZERO;
            rise_pend  <= RST_ZERO;
            fall_pend  <= RST_ZERO;
            high_pend  <= RST_ZERO;
            low_pend   <= RST_ZERO;
            irq_status <= RST_ZERO;
            irq_pin_o  <= RST_ZERO;
            irq_o      <= 1'b0;
            fn_level_o <= RST_ZERO;
        end else begin
            lvl_prev   <= lvl;
            rise_pend  <= next_rise_pend;
            fall_pend  <= next_fall_pend;
            high_pend  <= next_high_pend;
            low_pend   <= next_low_pend;
            irq_status <= next_status;
            irq_pin_o  <= next_irq_pin; // RULE8
            irq_o      <= |(irq_status & irq_mask);
            fn_level_o <= lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pad control: a missing function falls back to software.

    wire [31:0] fn_on    = fn_en & ((fn_sel & FN1_EXISTS) | (~fn_sel & FN0_EXISTS)); // RULE14
    wire [31:0] tk_value = taken(fn_on, fn_sel, TAKE_VALUE); // RULE13
    wire [31:0] tk_drive = taken(fn_on, fn_sel, TAKE_DRIVE); // RULE13
    wire [31:0] fn_out   = (fn_sel & fn1_out_i) | (~fn_sel & fn0_out_i); // RULE12
    wire [31:0] fn_drv   = (fn_sel & fn1_drive_i) | (~fn_sel & fn0_drive_i);
    wire [31:0] out_src  = (tk_value & fn_out) | (~tk_value & drive_level);
    wire [31:0] drv_src  = (tk_drive & fn_drv) | (~tk_drive & drive_en);

    // Pads are registered so every output leaves a flip-flop.
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            pad_out_o      <= RST_ZERO;
            pad_oe_n_o     <= RST_OE_N; // RULE9
            pad_sense_en_o <= RST_ZERO;
            pad_pullup_o   <= RST_ZERO;
            pad_strength_o <= RST_ZERO;
        end else begin
            pad_out_o      <= out_src ^ invert; // RULE11
            pad_oe_n_o     <= ~drv_src;
            pad_sense_en_o <= sense_en;
            pad_pullup_o   <= pullup_en; // RULE9
            pad_strength_o <= strength; // RULE10
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel: one read at a time, answered next cycle.

    wire        ar_take = arvalid_i & arready_o;
    wire        next_rv = (rvalid_o & ~rready_i) | ar_take;
    logic [31:0] rd_mux;
    logic        rd_ok;

    // Read selection; reserved or unmapped words read zero with an error.
    always_comb begin
        rd_ok  = (araddr_i[1:0] == 2'h0);
        rd_mux = RST_ZERO;
        case (araddr_i)
            OFF_LEVEL:      rd_mux = lvl; // RULE3
            OFF_SENSE:      rd_mux = sense_en;
            OFF_DRIVE:      rd_mux = drive_en;
            OFF_VALUE:      rd_mux = drive_level; // RULE2
            OFF_PULLUP:     rd_mux = pullup_en;
            OFF_STRENGTH:   rd_mux = strength;
            OFF_RISE_EN:    rd_mux = rise_en;
            OFF_RISE_PEND:  rd_mux = rise_pend;
            OFF_FALL_EN:    rd_mux = fall_en;
            OFF_FALL_PEND:  rd_mux = fall_pend;
            OFF_HIGH_EN:    rd_mux = high_en;
            OFF_HIGH_PEND:  rd_mux = high_pend;
            OFF_LOW_EN:     rd_mux = low_en;
            OFF_LOW_PEND:   rd_mux = low_pend;
            OFF_FN_EN:      rd_mux = fn_en;
            OFF_FN_SEL:     rd_mux = fn_sel;
            OFF_INVERT:     rd_mux = invert;
            OFF_DIRECT_HI:  rd_mux = direct_hi;
            OFF_DIRECT_LO:  rd_mux = direct_lo;
            OFF_IRQ_STATUS: rd_mux = irq_status;
            OFF_IRQ_MASK:   rd_mux = irq_mask;
            default:        rd_ok  = 1'b0;
        endcase
    end

    // Read answer registers.
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            rvalid_o  <= 1'b0;
            arready_o <= 1'b0;
            rdata_o   <= RST_ZERO;
            rresp_o   <= RESP_OKAY;
        end else begin
            rvalid_o  <= next_rv;
            arready_o <= ~next_rv;
            if (ar_take) begin
                rdata_o <= rd_mux; // RULE16
                rresp_o <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_read(logic [7:0] off);
        ar_take && araddr_i == off;
    endsequence

    a_level_read_gated: assert property (s_read(OFF_LEVEL) |=> rdata_o == $past(lvl)) // RULE3
        else $error("pin level read not gated by sense enable");
    a_value_readback: assert property (s_read(OFF_VALUE) |=> rdata_o == $past(drive_level)) // RULE2
        else $error("drive level readback wrong");
    a_rise_sets_pend: assert property (rise != 0 |=> (rise_pend & $past(rise)) == $past(rise)) // RULE6
        else $error("rising edge did not set pending");
    a_pend_sticky: assert property ((fall_pend & ~clr_fall) != 0 ##1 1'b1 // RULE7
        |-> (fall_pend & $past(fall_pend & ~clr_fall)) == $past(fall_pend & ~clr_fall))
        else $error("pending bit lost without clear");
    a_high_level_set: assert property (high_set != 0 |=> (high_pend & $past(high_set)) != 0) // RULE17
        else $error("high level did not set pending");
    a_pend_to_line: assert property (low_pend != 0 |=> (irq_pin_o & $past(low_pend)) == $past(low_pend)) // RULE6
        else $error("pending bit did not raise pin line");
    a_direct_path: assert property ((direct_lo & ~lvl) != 0 // RULE18
        |=> (irq_pin_o & $past(direct_lo & ~lvl)) == $past(direct_lo & ~lvl))
        else $error("direct low path not on pin line");
    a_sync_delay: assert property (pad_in_i != $past(pad_in_i) ##0 sense_en == 32'hffff_ffff [*3] // RULE5
        |-> lvl == $past(pad_in_i, 2))
        else $error("level not two stages behind pad");
    a_software_out: assert property (fn_en == 0 |=> pad_out_o == $past(drive_level ^ invert)) // RULE11
        else $error("software output not inverted correctly");
    a_missing_fn: assert property ((fn_en & ~fn_sel & ~FN0_EXISTS) != 0 // RULE14
        |=> ((pad_oe_n_o ^ ~$past(drive_en)) & $past(fn_en & ~fn_sel & ~FN0_EXISTS)) == 0)
        else $error("missing function took the pin");
    a_strength_follow: assert property (1'b1 |=> pad_strength_o == $past(strength)) // RULE10
        else $error("drive strength not applied");
    a_write_answer: assert property (do_wr |=> bvalid_o ##1 bvalid_o || $past(bready_i)) // RULE16
        else $error("write answer missing or dropped before bready");

endmodule : gpc_pin_ctrl

// ===== rtl/gpc_pin_sync.sv
// Two-stage synchroniser for the 32 pad input levels.
// Assumes the pads are asynchronous to mclk_i.
`timescale 1ns/10ps
module gpc_pin_sync
    import gpc_pkg::*;
(
    input  wire logic            mclk_i,
    input  wire logic            resetn_i,
    input  wire logic [NPIN-1:0] async_i,
    output logic      [NPIN-1:0] sync_o
);

    logic [NPIN-1:0] meta;

    // The first stage feeds only the second stage, limiting metastability.
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            meta   <= RST_ZERO;
            sync_o <= RST_ZERO;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end

endmodule : gpc_pin_sync

// ===== rtl/gpc_pkg.sv
// Package of the 32-pin controller: register offsets, reset values,
// bus answers and the fixed hardware-function maps.
// Assumes a 32-bit AXI4-Lite bus with byte addresses below 0x80.
package gpc_pkg;

    localparam int          NPIN            = 32;
    localparam int          AW              = 8;

    // Register byte offsets.
    localparam logic [7:0]  OFF_LEVEL       = 8'h00;
    localparam logic [7:0]  OFF_SENSE       = 8'h04;
    localparam logic [7:0]  OFF_DRIVE       = 8'h08;
    localparam logic [7:0]  OFF_VALUE       = 8'h0c;
    localparam logic [7:0]  OFF_PULLUP      = 8'h10;
    localparam logic [7:0]  OFF_STRENGTH    = 8'h14;
    localparam logic [7:0]  OFF_RISE_EN     = 8'h18;
    localparam logic [7:0]  OFF_RISE_PEND   = 8'h1c;
    localparam logic [7:0]  OFF_FALL_EN     = 8'h20;
    localparam logic [7:0]  OFF_FALL_PEND   = 8'h24;
    localparam logic [7:0]  OFF_HIGH_EN     = 8'h28;
    localparam logic [7:0]  OFF_HIGH_PEND   = 8'h2c;
    localparam logic [7:0]  OFF_LOW_EN      = 8'h30;
    localparam logic [7:0]  OFF_LOW_PEND    = 8'h34;
    localparam logic [7:0]  OFF_FN_EN       = 8'h38;
    localparam logic [7:0]  OFF_FN_SEL      = 8'h3c;
    localparam logic [7:0]  OFF_INVERT      = 8'h40;
    localparam logic [7:0]  OFF_DIRECT_HI   = 8'h44;
    localparam logic [7:0]  OFF_DIRECT_LO   = 8'h48;
    localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h4c;
    localparam logic [7:0]  OFF_IRQ_MASK    = 8'h50;

    // Every register except the pad output enables clears to zero.
    localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
    // Pads come out of reset not driven.
    localparam logic [31:0] RST_OE_N        = 32'hffff_ffff;

    // Bus answers.
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // Pins on which each hardware function exists.
    localparam logic [31:0] FN0_EXISTS      = 32'hfc87_37fc;
    localparam logic [31:0] FN1_EXISTS      = 32'h0078_3c0f;

    // Controls each function takes over: bit 0 value, bit 1 drive enable.
    localparam int          TAKE_VALUE      = 0;
    localparam int          TAKE_DRIVE      = 1;
    localparam logic [1:0]  FN0_TAKES       = 2'h3;
    localparam logic [1:0]  FN1_TAKES       = 2'h3;

endpackage : gpc_pkg
